/* verilog/sacc_pkg.sv */
package sacc_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CFG_OFS = 8'hbc;
	localparam logic [7:0] CTRL_OFS = 8'he8;
	localparam logic [7:0] RESL_OFS = 8'hc0;
	localparam logic [7:0] RESH_OFS = 8'hc4;
	localparam logic [7:0] WINH_OFS = 8'hc8;
	localparam logic [7:0] WINL_OFS = 8'hcc;
	localparam logic [7:0] IST_OFS = 8'hd0;
	localparam logic [7:0] ICLR_OFS = 8'hd4;
	localparam logic [7:0] IEN_OFS = 8'hd8;
	localparam logic [7:0] CFG_RST = 8'hf8;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [9:0] WINH_RST = 10'h000;
	localparam logic [9:0] WINL_RST = 10'h3ff;
	localparam logic [1:0] IEN_RST = 2'h0;
	localparam logic PIN_IDLE = 1'b1;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int EN_BIT = 7;
	localparam int TM_BIT = 6;
	localparam int INT_BIT = 5;
	localparam int BUSY_BIT = 4;
	localparam int CM_LSB = 2;
	localparam int WINT_BIT = 1;
	localparam int LJ_BIT = 0;
	localparam int SC_LSB = 3;

	// ----------------------------------------------------------------
	// Sequencer counts
	// ----------------------------------------------------------------
	localparam logic [1:0] TRACK_TICKS = 2'h3;
	localparam logic [3:0] MSB_IDX = 4'h9;

	typedef enum logic [1:0] {
		TRIG_SW = 2'b00,
		TRIG_T3 = 2'b01,
		TRIG_EXT = 2'b10,
		TRIG_T2 = 2'b11
	} sacc_trig_type;

	typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONV} sacc_seq_type;

	// Returns {high byte, low byte} of the result.
	function automatic logic [15:0] sacc_justify(input logic [9:0] r, input logic left);
		if (left) begin
			return {r, 6'h00};
		end
		return {6'h00, r};
	endfunction

	// Gain in half steps, so that 0.5 is representable.
	function automatic logic [5:0] sacc_gain_x2(input logic [2:0] g);
		case (g)
			3'h0: return 6'h02;
			3'h1: return 6'h04;
			3'h2: return 6'h08;
			3'h3: return 6'h10;
			3'h4, 3'h5: return 6'h20;
			default: return 6'h01;
		endcase
	endfunction

endpackage

/* verilog/sacc_conv_if.sv */
interface sacc_conv_if;
	logic start;
	logic long_track;
	logic abort;
	logic sar_tick;
	logic comp;
	logic busy;
	logic tracking;
	logic [9:0] trial_code;
	logic [9:0] result;
	logic result_valid;

	modport ctl(
		output start, long_track, abort, sar_tick, comp,
		input busy, tracking, trial_code, result, result_valid
	);
	modport seq(
		input start, long_track, abort, sar_tick, comp,
		output busy, tracking, trial_code, result, result_valid
	);
endinterface

/* verilog/sacc_sar_div.sv */
module sacc_sar_div
	import sacc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic run,
	input wire logic [4:0] divisor,
	output logic tick
);

	typedef struct packed {
		logic [4:0] cnt;
	} sacc_div_type;

	sacc_div_type s;
	sacc_div_type next_s;

	always_comb begin
		next_s = s;
		if (!run || s.cnt >= divisor) begin
			next_s.cnt = 5'h00;
		end else begin
			next_s.cnt = 5'(s.cnt + 5'h01);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = run && (s.cnt == divisor);

	tick_spacing_a:
	assert property (@(posedge clk) disable iff (!rst_b)
		tick && run && divisor != 5'h00 && $stable(divisor) |=> !tick)
		else $error("SAR clock ticks too close together.");

endmodule

/* verilog/sacc_sar_seq.sv */
module sacc_sar_seq
	import sacc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	sacc_conv_if.seq cv
);

	typedef struct packed {
		sacc_seq_type st;
		logic [1:0] trk;
		logic [3:0] idx;
		logic [9:0] code;
		logic done;
	} sacc_seq_state_type;

	sacc_seq_state_type s;
	sacc_seq_state_type next_s;
	logic [9:0] trial_bit;

	assign trial_bit = 10'(10'h001 << s.idx);

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		case (s.st)
			ST_IDLE: begin
				if (cv.start) begin
					next_s.code = 10'h000;
					next_s.idx = MSB_IDX;
					next_s.trk = 2'h0;
					next_s.st = cv.long_track ? ST_TRACK : ST_CONV;
				end
			end
			ST_TRACK: begin
				if (cv.sar_tick) begin
					if (s.trk == 2'(TRACK_TICKS - 2'h1)) begin
						next_s.st = ST_CONV;
					end else begin
						next_s.trk = 2'(s.trk + 2'h1);
					end
				end
			end
			default: begin
				if (cv.sar_tick) begin
					if (cv.comp) begin
						next_s.code = s.code | trial_bit;
					end
					if (s.idx == 4'h0) begin
						next_s.st = ST_IDLE;
						next_s.done = 1'b1;
					end else begin
						next_s.idx = 4'(s.idx - 4'h1);
					end
				end
			end
		endcase
		if (cv.abort) begin
			next_s.st = ST_IDLE;
			next_s.done = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s <= '{st: ST_IDLE, trk: 2'h0, idx: 4'h0, code: 10'h000, done: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign cv.busy = s.st != ST_IDLE;
	assign cv.tracking = s.st == ST_TRACK;
	assign cv.trial_code = (s.st == ST_CONV) ? (s.code | trial_bit) : s.code;
	assign cv.result = s.code;
	assign cv.result_valid = s.done;

	track_end_a:
	assert property (@(posedge clk) disable iff (!rst_b)
		s.st == ST_TRACK && cv.sar_tick && s.trk == 2'h2 && !cv.abort |=> s.st == ST_CONV)
		else $error("Tracking did not end after three SAR clocks.");

	busy_fall_a:
	assert property (@(posedge clk) disable iff (!rst_b)
		$fell(cv.busy) |-> cv.result_valid || $past(cv.abort))
		else $error("Busy fell without a finished conversion.");

endmodule

/* verilog/sacc_top.sv */
// The APB register port is this design's own decision.
module sacc_top
	import sacc_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Trigger sources
	input wire logic TIMER3_OVERFLOW,
	input wire logic TIMER2_OVERFLOW,
	input wire logic EXTERNAL_CONVERT_START,
	// Analog input path
	input wire logic COMPARATOR_OUT,
	output logic ANALOG_SHUTDOWN,
	output logic TRACK_ENABLE,
	output logic [9:0] TRIAL_CODE,
	output logic [2:0] PGA_GAIN_SELECT,
	output logic [5:0] PGA_GAIN_X2,
	// Status
	output logic CONVERSION_BUSY,
	output logic IRQ
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] cfg;
		logic en;
		logic tm;
		logic [1:0] cm;
		logic ljst;
		logic done_flag;
		logic win_flag;
		logic done_pend;
		logic win_pend;
		logic [7:0] res_hi;
		logic [7:0] res_lo;
		logic [9:0] win_hi;
		logic [9:0] win_lo;
		logic [1:0] irq_en;
		logic [31:0] prdata;
		logic pslverr;
		logic ext_s1;
		logic ext_s2;
		logic ext_q;
		logic cmp_s1;
		logic cmp_s2;
	} sacc_top_state_type;

	sacc_top_state_type s;
	sacc_top_state_type next_s;
	sacc_conv_if cv();
	logic sar_tick;
	logic setup;
	logic wr;
	logic wr_ctrl;
	logic sw_start;
	logic ext_rise;
	logic trig;
	logic win_match;
	logic [15:0] just;
	logic [1:0] status;
	logic [1:0] clr;

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	// divider restarts with each conversion
	// Restarting per conversion makes every SAR period, the first one too, full length.
	sacc_sar_div u_div (
		.clk(CLK),
		.rst_b(RST_B),
		.run(cv.busy),
		.divisor(s.cfg[7:SC_LSB]),
		.tick(sar_tick)
	);

	sacc_sar_seq u_seq (
		.clk(CLK),
		.rst_b(RST_B),
		.cv(cv.seq)
	);

	// ----------------------------------------------------------------
	// Trigger selection
	// ----------------------------------------------------------------
	assign setup = PSEL && !PENABLE;
	assign wr = PSEL && PENABLE && PWRITE;
	assign wr_ctrl = wr && PADDR == CTRL_OFS;
	// only a one written under software trigger
	assign sw_start = wr_ctrl && PWDATA[BUSY_BIT] && s.cm == TRIG_SW;
	assign ext_rise = s.ext_s2 && !s.ext_q;

	always_comb begin
		case (s.cm)
			TRIG_SW: trig = sw_start;
			TRIG_T3: trig = TIMER3_OVERFLOW;
			TRIG_EXT: trig = ext_rise;
			default: trig = TIMER2_OVERFLOW;
		endcase
	end

	assign cv.start = s.en && !cv.busy && trig;
	// the pin edge itself ends tracking
	assign cv.long_track = s.tm && s.cm != TRIG_EXT;
	assign cv.abort = !s.en;
	assign cv.sar_tick = sar_tick;
	// Decisions see the comparator two flops late, so a divider below two decides on a stale trial.
	assign cv.comp = s.cmp_s2;

	// ----------------------------------------------------------------
	// Result handling
	// ----------------------------------------------------------------
	// alignment chosen at load time
	assign just = sacc_justify(cv.result, s.ljst);
	assign win_match = cv.result >= s.win_lo && cv.result <= s.win_hi;
	assign status = {s.win_flag, s.done_flag};
	assign clr = (wr && PADDR == ICLR_OFS) ? PWDATA[1:0] : 2'h0;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.ext_s1 = EXTERNAL_CONVERT_START;
		next_s.ext_s2 = s.ext_s1;
		next_s.ext_q = s.ext_s2;
		next_s.cmp_s1 = COMPARATOR_OUT;
		next_s.cmp_s2 = s.cmp_s1;
		next_s.done_pend = 1'b0;
		next_s.win_pend = 1'b0;

		// load results one cycle ahead of flags
		if (cv.result_valid) begin
			next_s.res_hi = just[15:8];
			next_s.res_lo = just[7:0];
			next_s.done_pend = 1'b1;
			next_s.win_pend = win_match;
		end

		if (wr) begin
			if (PADDR == CFG_OFS) begin
				next_s.cfg = PWDATA[7:0];
			end else if (PADDR == CTRL_OFS) begin
				next_s.en = PWDATA[EN_BIT];
				next_s.tm = PWDATA[TM_BIT];
				next_s.cm = PWDATA[CM_LSB+1:CM_LSB];
				next_s.ljst = PWDATA[LJ_BIT];
				if (!PWDATA[INT_BIT]) begin
					next_s.done_flag = 1'b0;
				end
				if (!PWDATA[WINT_BIT]) begin
					next_s.win_flag = 1'b0;
				end
			end else if (PADDR == WINH_OFS) begin
				next_s.win_hi = PWDATA[9:0];
			end else if (PADDR == WINL_OFS) begin
				next_s.win_lo = PWDATA[9:0];
			end else if (PADDR == IEN_OFS) begin
				next_s.irq_en = PWDATA[1:0];
			end
		end
		if (clr[0]) begin
			next_s.done_flag = 1'b0;
		end
		if (clr[1]) begin
			next_s.win_flag = 1'b0;
		end
		// done flag set wins over clear
		if (s.done_pend) begin
			next_s.done_flag = 1'b1;
		end
		// window flag set wins over clear
		if (s.win_pend) begin
			next_s.win_flag = 1'b1;
		end

		// Read data is captured in the setup cycle so PRDATA comes from a flop.
		if (setup) begin
			next_s.pslverr = 1'b0;
			if (PADDR == CFG_OFS) begin
				next_s.prdata = {24'h0000_00, s.cfg};
			end else if (PADDR == CTRL_OFS) begin
				next_s.prdata = {24'h0000_00, s.en, s.tm, s.done_flag, cv.busy,
					s.cm, s.win_flag, s.ljst};
			end else if (PADDR == RESL_OFS) begin
				next_s.prdata = {24'h0000_00, s.res_lo};
			end else if (PADDR == RESH_OFS) begin
				next_s.prdata = {24'h0000_00, s.res_hi};
			end else if (PADDR == WINH_OFS) begin
				next_s.prdata = {22'h00_0000, s.win_hi};
			end else if (PADDR == WINL_OFS) begin
				next_s.prdata = {22'h00_0000, s.win_lo};
			end else if (PADDR == IST_OFS) begin
				next_s.prdata = {30'h0000_0000, status};
			end else if (PADDR == ICLR_OFS) begin
				next_s.prdata = 32'h0000_0000;
			end else if (PADDR == IEN_OFS) begin
				next_s.prdata = {30'h0000_0000, s.irq_en};
			end else begin
				next_s.prdata = 32'h0000_0000;
				next_s.pslverr = 1'b1;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			s <= '0;
			s.cfg <= CFG_RST;
			s.win_hi <= WINH_RST;
			s.win_lo <= WINL_RST;
			s.irq_en <= IEN_RST;
			// Starting at the pin's idle level keeps reset release from looking like a rise.
			s.ext_s1 <= PIN_IDLE;
			s.ext_s2 <= PIN_IDLE;
			s.ext_q <= PIN_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign PREADY = 1'b1;
	assign PRDATA = s.prdata;
	assign PSLVERR = s.pslverr & PSEL & PENABLE;
	assign ANALOG_SHUTDOWN = !s.en;

	always_comb begin
		if (!s.en) begin
			TRACK_ENABLE = 1'b0;
		end else if (!s.tm) begin
			TRACK_ENABLE = !cv.busy;
		end else if (s.cm == TRIG_EXT) begin
			// track while the pin is low
			TRACK_ENABLE = !s.ext_s2 && !cv.busy;
		end else begin
			TRACK_ENABLE = cv.tracking;
		end
	end

	assign TRIAL_CODE = cv.trial_code;
	assign PGA_GAIN_SELECT = s.cfg[2:0];
	assign PGA_GAIN_X2 = sacc_gain_x2(s.cfg[2:0]);
	assign CONVERSION_BUSY = cv.busy;
	assign IRQ = |(status & s.irq_en);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	shutdown_idle_a:
	assert property (@(posedge CLK) disable iff (!RST_B)
		!s.en |-> ANALOG_SHUTDOWN ##1 !cv.busy)
		else $error("Disabled converter is not idle.");

	continuous_track_a:
	assert property (@(posedge CLK) disable iff (!RST_B)
		s.en && !s.tm && !cv.busy |-> TRACK_ENABLE)
		else $error("No tracking in continuous track mode.");

	timer_start_a:
	assert property (@(posedge CLK) disable iff (!RST_B)
		s.en && !cv.busy && s.cm == TRIG_T3 && TIMER3_OVERFLOW |=> cv.busy)
		else $error("Timer 3 overflow did not start a conversion.");

	busy_write_a:
	assert property (@(posedge CLK) disable iff (!RST_B)
		wr_ctrl && s.cm == TRIG_SW && !PWDATA[BUSY_BIT] && !cv.busy |=> !cv.busy)
		else $error("Writing zero to busy started a conversion.");

	done_flag_a:
	assert property (@(posedge CLK) disable iff (!RST_B)
		cv.result_valid ##1 !clr[0] |=> s.done_flag)
		else $error("Done flag not set after a conversion.");

	pin_track_a:
	assert property (@(posedge CLK) disable iff (!RST_B)
		s.en && s.tm && s.cm == TRIG_EXT && s.ext_s2 |-> !TRACK_ENABLE)
		else $error("Tracking while the convert-start pin is high.");

	window_flag_a:
	assert property (@(posedge CLK) disable iff (!RST_B)
		s.win_flag && !clr[1] && !(wr_ctrl && !PWDATA[WINT_BIT]) |=> s.win_flag)
		else $error("Window flag dropped without a clear.");

	left_justify_a:
	assert property (@(posedge CLK) disable iff (!RST_B)
		cv.result_valid && s.ljst |=> s.res_lo[5:0] == 6'h00 && s.res_hi == $past(cv.result[9:2]))
		else $error("Left-justified result misplaced.");

	half_gain_a:
	assert property (@(posedge CLK) disable iff (!RST_B)
		s.cfg[2:1] == 2'b11 |-> PGA_GAIN_X2 == 6'h01)
		else $error("Gain code 11x is not one half.");

	result_first_a:
	assert property (@(posedge CLK) disable iff (!RST_B)
		$rose(s.done_flag) |-> $past(s.done_pend) && $stable(s.res_lo))
		else $error("Done flag rose before the result loaded.");

endmodule

/* verif/sacc_analog_model.sv */
module sacc_analog_model (
	// Clock
	input wire logic clk,
	// Converter side
	input wire logic shutdown,
	input wire logic [9:0] trial_code,
	output logic comparator_out,
	output logic convert_start,
	// Bench control
	input wire logic [9:0] vin,
	input wire logic pin_req
);
	timeunit 1ns;
	timeprecision 100ps;

	logic scramble = 1'b0;
	logic pin = 1'b1;

	always @(posedge clk) begin
		scramble <= ~scramble;
		pin <= pin_req;
	end

	// no decision off
	// A powered-down comparator gives no valid decision, so it wanders every cycle.
	assign comparator_out = shutdown ? scramble : (vin >= trial_code);

	assign convert_start = pin;
endmodule

/* verif/tb_sacc_top.sv */
module tb_sacc_top
	import sacc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic t3 = 1'b0;
	logic t2 = 1'b0;
	logic [9:0] vin = 10'h2a5;
	logic pin_req = 1'b1;
	logic [31:0] prdata;
	logic pready, pslverr, ext_start, comp, shutdown, track, busy, irq;
	logic [9:0] trial;
	logic [2:0] gain;
	logic [5:0] gain_x2;
	logic [31:0] rd;
	logic er, trk;
	logic [5:0] gx [8] = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h20, 6'h01, 6'h01};
	logic [1:0] cds [3] = '{2'b01, 2'b11, 2'b00};
	int errors = 0;
	int samples_checked = 0;
	int len;

	sacc_top i_sacc_top (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .TIMER3_OVERFLOW(t3), .TIMER2_OVERFLOW(t2),
		.EXTERNAL_CONVERT_START(ext_start), .COMPARATOR_OUT(comp), .ANALOG_SHUTDOWN(shutdown),
		.TRACK_ENABLE(track), .TRIAL_CODE(trial), .PGA_GAIN_SELECT(gain),
		.PGA_GAIN_X2(gain_x2), .CONVERSION_BUSY(busy), .IRQ(irq));

	sacc_analog_model i_sacc_analog_model (.clk(clk), .shutdown(shutdown), .trial_code(trial),
		.comparator_out(comp), .convert_start(ext_start), .vin(vin), .pin_req(pin_req));

	initial begin
		forever #2 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Read data and error are taken at the edge that ends the access.
	// The task returns at the next falling edge, so outputs checked after it have settled.
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (n >= 100) begin
			errors++;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0000_0000);
		check(rd, exp);
	endtask

	// Fires the selected software or timer source when good is set, every unselected timer overflows otherwise.
	task automatic fire(input logic [1:0] c, input logic good, input logic [31:0] ctl);
		if (c == 2'b00 && good) begin
			wr(CTRL_OFS, ctl | 32'h0000_0010);
		end else begin
			@(posedge clk);
			t3 <= ((c == 2'b01) == good);
			t2 <= ((c == 2'b11) == good);
			@(posedge clk);
			t3 <= 1'b0;
			t2 <= 1'b0;
			@(negedge clk);
		end
	endtask

	// Counts busy cycles; zero means no conversion started.
	task automatic conv(output int n);
		int k;
		n = 0;
		k = 0;
		while (busy !== 1'b1 && k < 40) begin
			@(negedge clk);
			k++;
		end
		while (busy === 1'b1 && n < 2000) begin
			trk = track;
			@(negedge clk);
			n++;
		end
		repeat (2) @(negedge clk);
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		rdc(CFG_OFS, 32'h0000_00f8);
		rdc(CTRL_OFS, 32'h0000_0000);
		rdc(IEN_OFS, 32'h0000_0000);
		check(shutdown, 1'b1);
		check({pready, trial}, 32'h0000_0400);
		xfer(8'h04, 1'b0, 32'h0000_0000);
		check(er, 1'b1);
		check(rd, 32'h0000_0000);
		$display("reset test ended");
		for (int g = 0; g < 8; g++) begin
			wr(CFG_OFS, 32'h0000_0010 | g);
			rdc(CFG_OFS, 32'h0000_0010 | g);
			check({gain, gain_x2}, {g[2:0], gx[g]});
		end
		$display("gain test ended");
		wr(CTRL_OFS, 32'h0000_0010);
		conv(len);
		check(len, 0);
		wr(CTRL_OFS, 32'h0000_0080);
		check({shutdown, track}, 2'b01);
		conv(len);
		check(len, 0);
		wr(CTRL_OFS, 32'h0000_0090);
		conv(len);
		check(len, 30);
		check({trk, track}, 2'b01);
		rdc(CTRL_OFS, 32'h0000_00a0);
		rdc(RESL_OFS, 32'h0000_00a5);
		rdc(RESH_OFS, 32'h0000_0002);
		rdc(IST_OFS, 32'h0000_0001);
		check(irq, 1'b0);
		wr(IEN_OFS, 32'h0000_0001);
		check(irq, 1'b1);
		wr(ICLR_OFS, 32'h0000_0001);
		check(irq, 1'b0);
		rdc(IST_OFS, 32'h0000_0000);
		rdc(ICLR_OFS, 32'h0000_0000);
		$display("software conversion test ended");
		wr(CFG_OFS, 32'h0000_0010);
		vin <= 10'h13e;
		wr(WINL_OFS, 32'h0000_013e);
		wr(WINH_OFS, 32'h0000_013e);
		wr(CTRL_OFS, 32'h0000_0091);
		conv(len);
		check(len, 30);
		rdc(RESH_OFS, 32'h0000_004f);
		rdc(RESL_OFS, 32'h0000_0080);
		rdc(CTRL_OFS, 32'h0000_00a3);
		wr(ICLR_OFS, 32'h0000_0001);
		wr(IEN_OFS, 32'h0000_0002);
		rdc(IST_OFS, 32'h0000_0002);
		check(irq, 1'b1);
		wr(ICLR_OFS, 32'h0000_0002);
		check(irq, 1'b0);
		vin <= 10'h13f;
		wr(CTRL_OFS, 32'h0000_0090);
		conv(len);
		rdc(IST_OFS, 32'h0000_0001);
		wr(ICLR_OFS, 32'h0000_0003);
		$display("window test ended");
		wr(CFG_OFS, 32'h0000_0000);
		for (int i = 0; i < 6; i++) begin
			len = 32'h0000_0080 | ((i / 3) << 6) | (cds[i % 3] << 2);
			wr(CTRL_OFS, len);
			fire(cds[i % 3], 1'b0, len);
			conv(len);
			check(len, 0);
			len = 32'h0000_0080 | ((i / 3) << 6) | (cds[i % 3] << 2);
			fire(cds[i % 3], 1'b1, len);
			conv(len);
			check(len, (i < 3) ? 10 : 13);
			wr(ICLR_OFS, 32'h0000_0003);
		end
		$display("trigger test ended");
		wr(CFG_OFS, 32'h0000_0010);
		wr(CTRL_OFS, 32'h0000_00c8);
		@(posedge clk);
		pin_req <= 1'b0;
		repeat (8) @(posedge clk);
		check({track, busy}, 2'b10);
		pin_req <= 1'b1;
		conv(len);
		check(len, 30);
		check(track, 1'b0);
		rdc(RESL_OFS, 32'h0000_003f);
		wr(CTRL_OFS, 32'h0000_0000);
		check(shutdown, 1'b1);
		$display("pin test ended");
		give_verdict();
	end

	initial begin
		#(40000 * 4);
		errors++;
		give_verdict();
	end
endmodule
